/* su_serial_unit.v */
/*
 * Serial unit: APB register slave, asynchronous transmitter and
 * receiver with parity and multiprocessor formats, clocked-synchronous
 * 8-bit transfer, and four gated interrupt requests on one shared line.
 * Assumes a 50 MHz i_ref_clk, serial pins from outside this clock domain
 * (synchronised here), and an APB master that honours pready.
 */
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ns
`include "su_defs.vh"

module su_serial_unit #(
	parameter [15:0] BIT_CYC  = `SU_BIT_CYC,
	parameter [7:0]  SCK_HALF = `SU_SCK_HALF
) (
	input  wire        i_ref_clk,
	input  wire        i_sys_rst,
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [11:0] i_paddr,
	input  wire [31:0] i_pwdata,
	output reg  [31:0] o_prdata,
	output wire        o_pready,
	output wire        o_pslverr,
	input  wire        i_serial_rx_pin,
	output reg         o_serial_tx_pin,
	input  wire        i_sck,
	output wire        o_sck,
	output wire        o_sck_oe,
	output wire        o_rx_full_irq,
	output wire        o_rx_error_irq,
	output wire        o_tx_empty_irq,
	output wire        o_tx_end_irq,
	output wire        o_irq
);

	// One-hot frame states, shared by transmitter and receiver
	localparam [4:0] ST_IDLE  = 5'h01;
	localparam [4:0] ST_START = 5'h02;
	localparam [4:0] ST_DATA  = 5'h04;
	localparam [4:0] ST_EXTRA = 5'h08;
	localparam [4:0] ST_STOP  = 5'h10;

	// Parity of the data bits; odd mode inverts
	function su_par;
		input [7:0] d;
		input       chr7;
		input       odd;
		begin
			su_par = ^{d[7] & ~chr7, d[6:0]} ^ odd;
		end
	endfunction

	reg [`SU_CTRL_W-1:0] serial_control_reg;
	reg [7:0]  tx_data_reg;
	reg [7:0]  tx_shift_reg;
	reg [7:0]  rx_data_reg;
	reg [7:0]  rx_shift_reg;
	reg        tx_empty_flag;
	reg        tx_end_flag;
	reg        rx_full_flag;
	reg        overrun_flag;
	reg        framing_error_flag;
	reg        parity_error_flag;
	reg        mp_rx_bit;
	reg [1:0]  rx_sync;
	reg [1:0]  sck_sync;
	reg        rx_prev;
	reg        sck_prev;
	reg        int_sck;
	reg [7:0]  half_cnt;
	reg [3:0]  sync_cnt;
	reg [4:0]  t_st;
	reg [15:0] t_tim;
	reg [3:0]  t_idx;
	reg        t_next;
	reg [4:0]  r_st;
	reg [15:0] r_tim;
	reg [3:0]  r_idx;
	reg        r_ext;

	wire tx_en   = serial_control_reg[`SU_C_TX_EN];
	wire rx_en   = serial_control_reg[`SU_C_RX_EN];
	wire id_wait = serial_control_reg[`SU_C_ID_WAIT];
	wire sync_md = serial_control_reg[`SU_C_SYNC];
	wire ck_out  = serial_control_reg[`SU_C_CK_OUT];
	wire chr7    = serial_control_reg[`SU_C_CHR7];
	wire stop2   = serial_control_reg[`SU_C_STOP2];
	wire mp_md   = serial_control_reg[`SU_C_MP];
	wire par_en  = serial_control_reg[`SU_C_PAR_EN];
	wire par_odd = serial_control_reg[`SU_C_PAR_ODD];
	wire rxd     = rx_sync[1];
	wire rx_err  = overrun_flag | framing_error_flag | parity_error_flag;
	wire has_ext = mp_md | par_en;
	wire [3:0] nbits = chr7 ? 4'd7 : 4'd8;

	// APB: zero wait states, unmapped offsets answer with pslverr
	wire acc    = i_psel & i_penable;
	wire mapped = (i_paddr == `SU_ADDR_TXDATA) |
		(i_paddr == `SU_ADDR_RXDATA) | (i_paddr == `SU_ADDR_CTRL) |
		(i_paddr == `SU_ADDR_STATUS);
	assign o_pready  = 1'b1;
	assign o_pslverr = acc & ~mapped;
	wire wr_tx   = acc & i_pwrite & (i_paddr == `SU_ADDR_TXDATA);
	wire rd_rx   = acc & ~i_pwrite & (i_paddr == `SU_ADDR_RXDATA);
	wire wr_ctrl = acc & i_pwrite & (i_paddr == `SU_ADDR_CTRL);
	wire wr_stat = acc & i_pwrite & (i_paddr == `SU_ADDR_STATUS);

	// effective serial clock and its edges
	wire sck_eff = ck_out ? int_sck : sck_sync[1];
	wire sck_r   = sync_md & sck_eff & ~sck_prev;
	wire sck_f   = sync_md & ~sck_eff & sck_prev;
	wire sync_tx = sync_md & (t_st == ST_DATA);
	wire sync_run = sync_tx | (rx_en & ~rx_err & ~rx_full_flag);
	assign o_sck    = int_sck;
	assign o_sck_oe = sync_md & ck_out;

	// Character completion, async stop sample or eighth rising edge
	wire a_fin = (r_st == ST_STOP) & (r_tim == BIT_CYC - 16'd1);
	// eighth rising edge ends a fixed 8-bit character
	wire s_fin = sck_r & rx_en & ~rx_err & (sync_cnt == 4'd7);
	wire [7:0] fin_byte = s_fin ? {rxd, rx_shift_reg[6:0]} : rx_shift_reg;
	wire fin_fe = a_fin & ~rxd;
	wire fin_pe = a_fin & par_en & ~mp_md &
		(su_par(rx_shift_reg, chr7, par_odd) != r_ext);
	// data frames dropped while waiting for an ID
	wire fin_skip = a_fin & mp_md & id_wait & ~r_ext;
	wire fin = (a_fin | s_fin) & ~fin_skip;

	// four gated requests merged onto one request line
	assign o_rx_full_irq  = serial_control_reg[`SU_C_RX_IE] & rx_full_flag;
	assign o_rx_error_irq = serial_control_reg[`SU_C_RX_IE] & rx_err;
	assign o_tx_empty_irq = serial_control_reg[`SU_C_TXE_IE] & tx_empty_flag;
	assign o_tx_end_irq   = serial_control_reg[`SU_C_TX_END_FLAG_IE] & tx_end_flag;
	assign o_irq = o_rx_full_irq | o_rx_error_irq | o_tx_empty_irq |
		o_tx_end_irq;

	// Pin synchronisers and edge history
	always @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rx_sync  <= 2'h3;
			sck_sync <= 2'h3;
			rx_prev  <= 1'b1;
			sck_prev <= 1'b1;
		end else begin
			rx_sync  <= {rx_sync[0], i_serial_rx_pin};
			sck_sync <= {sck_sync[0], i_sck};
			rx_prev  <= rxd;
			sck_prev <= sck_eff;
		end
	end

	// Read data is latched in the setup phase, valid during access
	always @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_prdata <= 32'h00000000;
		end else if (i_psel & ~i_penable) begin
			if (i_paddr == `SU_ADDR_TXDATA) begin
				o_prdata <= {24'h000000, tx_data_reg};
			end else if (i_paddr == `SU_ADDR_RXDATA) begin
				o_prdata <= {24'h000000, rx_data_reg};
			end else if (i_paddr == `SU_ADDR_CTRL) begin
				o_prdata <= {18'h00000, serial_control_reg};
			end else if (i_paddr == `SU_ADDR_STATUS) begin
				o_prdata <= {24'h000000, rxd, mp_rx_bit, tx_end_flag,
					parity_error_flag, framing_error_flag, overrun_flag,
					rx_full_flag, tx_empty_flag};
			end else begin
				o_prdata <= 32'h00000000;
			end
		end
	end

	// Internal serial clock: idles high, pulses only while work remains
	always @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			int_sck  <= 1'b1;
			half_cnt <= 8'h00;
		end else if (sync_md & ck_out) begin
			if (half_cnt == SCK_HALF - 8'd1) begin
				half_cnt <= 8'h00;
				if (!int_sck)
					int_sck <= 1'b1;
				else if (sync_cnt != 4'd0 || sync_run)
					int_sck <= 1'b0;
			end else begin
				half_cnt <= half_cnt + 8'd1;
			end
		end else begin
			int_sck  <= 1'b1;
			half_cnt <= 8'h00;
		end
	end

	// Registers, flags and both frame engines
	always @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			serial_control_reg <= `SU_CTRL_RST;
			tx_data_reg     <= 8'h00;
			tx_shift_reg    <= 8'h00;
			rx_data_reg     <= 8'h00;
			rx_shift_reg    <= 8'h00;
			tx_empty_flag   <= 1'b1;
			tx_end_flag     <= 1'b1;
			rx_full_flag    <= 1'b0;
			overrun_flag    <= 1'b0;
			framing_error_flag <= 1'b0;
			parity_error_flag  <= 1'b0;
			mp_rx_bit       <= 1'b0;
			o_serial_tx_pin <= 1'b1;
			sync_cnt <= 4'h0;
			t_st  <= ST_IDLE;
			t_tim <= 16'h0000;
			t_idx <= 4'h0;
			t_next <= 1'b0;
			r_st  <= ST_IDLE;
			r_tim <= 16'h0000;
			r_idx <= 4'h0;
			r_ext <= 1'b0;
		end else begin
			// Software side: clears first so hardware sets below win
			if (wr_ctrl)
				serial_control_reg <= i_pwdata[`SU_CTRL_W-1:0];
			if (wr_tx) begin
				tx_data_reg <= i_pwdata[7:0];
				tx_empty_flag <= 1'b0;
				tx_end_flag   <= 1'b0;
			end
			if (rd_rx)
				rx_full_flag <= 1'b0;
			// software write of 0 clears the receive flags
			if (wr_stat) begin
				if (!i_pwdata[`SU_S_RX_FULL])
					rx_full_flag <= 1'b0;
				if (!i_pwdata[`SU_S_OVERRUN])
					overrun_flag <= 1'b0;
				if (!i_pwdata[`SU_S_FRAMING])
					framing_error_flag <= 1'b0;
				if (!i_pwdata[`SU_S_PARITY])
					parity_error_flag <= 1'b0;
			end

			// Synchronous engine, shared bit count for both directions
			if (!sync_md) begin
				sync_cnt <= 4'h0;
			end else begin
				if (t_st == ST_IDLE && tx_en && !tx_empty_flag &&
					!rx_err && sync_cnt == 4'd0) begin
					tx_shift_reg    <= tx_data_reg;
					tx_empty_flag   <= 1'b1;
					tx_end_flag     <= 1'b0;
					o_serial_tx_pin <= tx_data_reg[0];
					t_next <= 1'b0;
					t_st   <= ST_DATA;
				end
				if (sck_r) begin
					sync_cnt <= (sync_cnt == 4'd7) ? 4'h0 : sync_cnt + 4'd1;
					if (rx_en && !rx_err)
						rx_shift_reg[sync_cnt[2:0]] <= rxd;
					if (sync_cnt == 4'd7 && t_st == ST_DATA) begin
						if (!tx_empty_flag && !rx_err) begin
							tx_shift_reg  <= tx_data_reg;
							tx_empty_flag <= 1'b1;
							t_next <= 1'b1;
						end else begin
							// Line keeps the MSB after the last bit
							tx_end_flag <= 1'b1;
							t_st <= ST_IDLE;
						end
					end
				end
				if (sck_f && t_st == ST_DATA) begin
					if (sync_cnt != 4'd0) begin
						o_serial_tx_pin <= tx_shift_reg[sync_cnt[2:0]];
					end else if (t_next) begin
						o_serial_tx_pin <= tx_shift_reg[0];
						t_next <= 1'b0;
					end
				end
			end

			// Asynchronous transmitter
			if (!sync_md) begin
				if (t_st == ST_IDLE) begin
					if (tx_en && !tx_empty_flag) begin
						// load, flag empty, send start bit
						tx_shift_reg    <= tx_data_reg;
						tx_empty_flag   <= 1'b1;
						tx_end_flag     <= 1'b0;
						o_serial_tx_pin <= 1'b0;
						t_st  <= ST_START;
						t_tim <= 16'h0000;
					end
				end else if (t_tim != BIT_CYC - 16'd1) begin
					t_tim <= t_tim + 16'd1;
				end else begin
					t_tim <= 16'h0000;
					case (t_st)
					ST_START: begin
						o_serial_tx_pin <= tx_shift_reg[0];
						t_idx <= 4'd1;
						t_st  <= ST_DATA;
					end
					ST_DATA: begin
						if (t_idx != nbits) begin
							o_serial_tx_pin <= tx_shift_reg[t_idx[2:0]];
							t_idx <= t_idx + 4'd1;
						end else if (has_ext) begin
							// ID or data marker, or parity when not in mp mode, in the extra bit
							o_serial_tx_pin <= mp_md ?
								serial_control_reg[`SU_C_MP_TXBIT] :
								su_par(tx_shift_reg, chr7, par_odd);
							t_st <= ST_EXTRA;
						end else begin
							o_serial_tx_pin <= 1'b1;
							t_idx <= 4'd0;
							t_st  <= ST_STOP;
						end
					end
					ST_EXTRA: begin
						o_serial_tx_pin <= 1'b1;
						t_idx <= 4'd0;
						t_st  <= ST_STOP;
					end
					default: begin
						if (t_next) begin
							o_serial_tx_pin <= 1'b0;
							t_next <= 1'b0;
							t_st   <= ST_START;
						end else if (!(stop2 && t_idx == 4'd0)) begin
							t_st <= ST_IDLE;
						end
						t_idx <= 4'd1;
					end
					endcase
				end
				// Empty flag is tested as the last stop bit begins
				if (t_tim == 16'h0000 && t_st == ST_STOP &&
					(t_idx == 4'd1) == stop2 && !t_next) begin
					if (!tx_empty_flag) begin
						tx_shift_reg  <= tx_data_reg;
						tx_empty_flag <= 1'b1;
						t_next <= 1'b1;
					end else begin
						// mark level follows, end flag set
						tx_end_flag <= 1'b1;
					end
				end
			end

			// Asynchronous receiver, mid-bit sampling
			if (sync_md || !rx_en) begin
				r_st <= ST_IDLE;
			end else if (r_st == ST_IDLE) begin
				// start bits ignored while an error stands
				if (rx_prev && !rxd && !rx_err) begin
					r_st  <= ST_START;
					r_tim <= 16'h0000;
				end
			end else if (r_st == ST_START) begin
				if (r_tim == (BIT_CYC >> 1) - 16'd1) begin
					r_tim <= 16'h0000;
					r_idx <= 4'h0;
					rx_shift_reg <= 8'h00;
					r_st  <= rxd ? ST_IDLE : ST_DATA;
				end else begin
					r_tim <= r_tim + 16'd1;
				end
			end else if (r_tim != BIT_CYC - 16'd1) begin
				r_tim <= r_tim + 16'd1;
			end else begin
				r_tim <= 16'h0000;
				case (r_st)
				ST_DATA: begin
					rx_shift_reg[r_idx[2:0]] <= rxd;
					r_idx <= r_idx + 4'd1;
					if (r_idx == nbits - 4'd1)
						r_st <= has_ext ? ST_EXTRA : ST_STOP;
				end
				ST_EXTRA: begin
					r_ext <= rxd;
					r_st  <= ST_STOP;
				end
				default: begin
					r_st <= ST_IDLE;
				end
				endcase
			end

			// Completion: store or overrun, after software clears
			if (fin) begin
				if (rx_full_flag) begin
					// overrun keeps old data and full flag
					overrun_flag <= 1'b1;
					rx_full_flag <= 1'b1;
				end else begin
					rx_data_reg  <= fin_byte;
					rx_full_flag <= 1'b1;
				end
				if (fin_fe)
					framing_error_flag <= 1'b1;
				if (fin_pe)
					parity_error_flag <= 1'b1;
				mp_rx_bit <= a_fin & mp_md & r_ext;
				// an ID frame ends the wait
				if (a_fin && mp_md && r_ext)
					serial_control_reg[`SU_C_ID_WAIT] <= 1'b0;
			end
		end
	end

endmodule // su_serial_unit

/* su_defs.vh */
/*
 * Constants of the serial unit: register byte offsets, control and
 * status bit positions, reset values and timing counts.
 * Assumes inclusion by su_serial_unit.v only; definitions only.
 */
`ifndef SU_DEFS_VH
`define SU_DEFS_VH

// Register byte offsets on the APB
`define SU_ADDR_TXDATA 12'h000
`define SU_ADDR_RXDATA 12'h004
`define SU_ADDR_CTRL   12'h008
`define SU_ADDR_STATUS 12'h00c

// Control register bit positions
`define SU_C_TX_EN     0
`define SU_C_RX_EN     1
`define SU_C_RX_IE     2
`define SU_C_TXE_IE    3
`define SU_C_TX_END_FLAG_IE   4
`define SU_C_ID_WAIT   5
`define SU_C_SYNC      6
`define SU_C_CK_OUT    7
`define SU_C_CHR7      8
`define SU_C_STOP2     9
`define SU_C_MP        10
`define SU_C_PAR_EN    11
`define SU_C_PAR_ODD   12
`define SU_C_MP_TXBIT  13
`define SU_CTRL_W      14
`define SU_CTRL_RST    14'h0000

// Status register bit positions
`define SU_S_TX_EMPTY  0
`define SU_S_RX_FULL   1
`define SU_S_OVERRUN   2
`define SU_S_FRAMING   3
`define SU_S_PARITY    4
`define SU_S_TX_END    5
`define SU_S_MP_RX     6
`define SU_S_RX_PIN    7

// Timing counts in system clock cycles
`define SU_BIT_CYC     16'd434
`define SU_SCK_HALF    8'd4

`endif

/* su_serial_unit_asserts.sv */
/* Checker of the serial unit top ports: APB answers, interrupt lines
   and the transmit line. Assumes binding to su_serial_unit. */
`timescale 1ns/1ns
module su_serial_unit_chk #(
	parameter [15:0] BIT_CYC  = 16'd434,
	parameter [7:0]  SCK_HALF = 8'd4
) (
	input wire        i_ref_clk,
	input wire        i_sys_rst,
	input wire        i_psel,
	input wire        i_penable,
	input wire        i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	input wire [31:0] o_prdata,
	input wire        o_pready,
	input wire        o_pslverr,
	input wire        i_serial_rx_pin,
	input wire        o_serial_tx_pin,
	input wire        i_sck,
	input wire        o_sck,
	input wire        o_sck_oe,
	input wire        o_rx_full_irq,
	input wire        o_rx_error_irq,
	input wire        o_tx_empty_irq,
	input wire        o_tx_end_irq,
	input wire        o_irq
);
	// Decoded APB access kinds
	wire acc   = i_psel & i_penable;
	wire mapd  = (i_paddr[11:4] == 8'h00) && (i_paddr[1:0] == 2'b00);
	wire wr    = acc & i_pwrite;
	wire rd_rx = acc & !i_pwrite & (i_paddr == 12'h004);
	wire wr_tx = wr & (i_paddr == 12'h000);

	// Sync mode seen from control writes; there the line keeps the MSB
	reg ck_sync;
	always @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			ck_sync <= 1'b0;
		else if (wr && i_paddr == 12'h008)
			ck_sync <= i_pwdata[6];
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	a_irq_or: assert property (
		o_irq == (o_rx_full_irq | o_rx_error_irq | o_tx_empty_irq
		| o_tx_end_irq)) else $error("shared irq differs from causes");
	a_slverr_map: assert property (
		acc |-> o_pslverr == !mapd) else $error("slave error misdecoded");
	a_unmap_zero: assert property (acc && !i_pwrite && !mapd
		|-> o_prdata == 32'h0) else $error("unmapped read not zero");
	a_rst_idle: assert property ($past(i_sys_rst) |-> o_serial_tx_pin
		&& o_sck && !o_sck_oe && !o_irq) else $error("bad reset state");
	a_err_hold: assert property (
		o_rx_error_irq && !wr |=> o_rx_error_irq)
		else $error("error request dropped without a write");
	a_rxf_clear: assert property (
		rd_rx && o_rx_full_irq && !o_rx_error_irq |=> !o_rx_full_irq)
		else $error("receive data read left full request");
	a_txe_clear: assert property (
		wr_tx && o_tx_empty_irq |=> !o_tx_empty_irq)
		else $error("transmit write left empty request");
	a_tx_end_flag_idle: assert property (
		(!ck_sync && o_tx_end_irq) [*2] |-> o_serial_tx_pin)
		else $error("line not idle high after end");
endmodule // su_serial_unit_chk

bind su_serial_unit su_serial_unit_chk #(
	.BIT_CYC(BIT_CYC), .SCK_HALF(SCK_HALF)
) i_su_serial_unit_chk (
	.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .i_serial_rx_pin(i_serial_rx_pin),
	.o_serial_tx_pin(o_serial_tx_pin), .i_sck(i_sck), .o_sck(o_sck),
	.o_sck_oe(o_sck_oe), .o_rx_full_irq(o_rx_full_irq),
	.o_rx_error_irq(o_rx_error_irq), .o_tx_empty_irq(o_tx_empty_irq),
	.o_tx_end_irq(o_tx_end_irq), .o_irq(o_irq));

/* su_far_node.sv */
/* Far serial node: sends async and clocked frames to the unit and
   captures its async and clocked frames. Assumes one task at a time
   per line, and that the unit drives the clock when it sends clocked. */
`timescale 1ns/1ns
module su_far_node #(
	parameter int BIT_NS = 320
) (
	input  wire  i_tx_line,
	input  wire  i_dev_sck,
	output logic o_rx_line,
	output logic o_sck
);
	// Line and clock start high; after a clocked frame the line holds ~d[7]
	initial begin
		o_rx_line = 1'b1;
		o_sck = 1'b1;
	end

	// start, data LSB first, mp bit, stop
	task send_async(input logic [7:0] d, input logic mp);
		logic [10:0] f;
		f = {1'b1, mp, d, 1'b0};
		// Non-blocking so the unit's clock edge sees the old level
		for (int k = 0; k < 11; k++) begin
			o_rx_line <= f[k];
			#(BIT_NS);
		end
	endtask

	// data on falling edge, 160 ns clock, 8 pulses
	task send_sync(input logic [7:0] d);
		for (int k = 0; k < 8; k++) begin
			o_sck <= 1'b0;
			o_rx_line <= d[k];
			#80;
			o_sck <= 1'b1;
			#80;
		end
		// Released line no longer shows the last bit
		o_rx_line <= ~d[7];
		#160;
	endtask

	// unit drives the clock; sample on its rising edge
	task get_sync(output logic [7:0] d, output logic ok);
		int w;
		ok = 1'b1;
		// Offset keeps polls off the unit's clock edges
		#1;
		for (int k = 0; k < 8; k++) begin
			w = 0;
			while (i_dev_sck !== 1'b0 && w < 500) begin
				#5;
				w++;
			end
			while (i_dev_sck !== 1'b1 && w < 500) begin
				#5;
				w++;
			end
			if (w >= 500)
				ok = 1'b0;
			d[k] = i_tx_line;
		end
	endtask

	// Mid-bit sampling; w counts 20 ns waits for the start bit
	task get_async(output logic [7:0] d, output logic mp,
		output logic ok, output int w);
		w = 0;
		// Offset keeps polls off the unit's clock edges
		#1;
		while (i_tx_line !== 1'b0 && w < 2000) begin
			#20;
			w++;
		end
		#(BIT_NS * 3 / 2);
		for (int k = 0; k < 8; k++) begin
			d[k] = i_tx_line;
			#(BIT_NS);
		end
		mp = i_tx_line;
		#(BIT_NS);
		ok = (w < 2000) && (i_tx_line === 1'b1);
	endtask
endmodule // su_far_node

/* tb_su_serial_unit.sv */
/* Testbench of the serial unit: APB master, one task per scenario.
   Assumes the bound checker and the far node on the serial pins. */
`timescale 1ns/1ns
module tb_su_serial_unit;
	localparam [11:0] A_TX = 12'h000, A_RX = 12'h004;
	localparam [11:0] A_CT = 12'h008, A_ST = 12'h00c;
	logic        i_ref_clk = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, serr, rx_line, sck_ext, tx_pin;
	logic        irq_rf, irq_re, irq_te, irq_tn, irq, mp, ok;
	logic        sck_dev, sck_oe;
	logic [7:0]  d;
	int          w, err_total = 0, n_checks = 0;

	always #10 i_ref_clk = ~i_ref_clk;

	// Short bit and clock counts keep the run brief
	su_serial_unit #(.BIT_CYC(16'd16), .SCK_HALF(8'd2)) i_su_serial_unit (
		.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_serial_rx_pin(rx_line),
		.o_serial_tx_pin(tx_pin), .i_sck(sck_ext), .o_sck(sck_dev),
		.o_sck_oe(sck_oe), .o_rx_full_irq(irq_rf),
		.o_rx_error_irq(irq_re),
		.o_tx_empty_irq(irq_te), .o_tx_end_irq(irq_tn), .o_irq(irq));

	su_far_node #(.BIT_NS(320)) i_su_far_node (
		.i_tx_line(tx_pin), .i_dev_sck(sck_dev), .o_rx_line(rx_line),
		.o_sck(sck_ext));

	task test_done;
		$display("Checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One transfer; held until pready is seen high at an edge
	task apb(input logic we, input logic [11:0] a, input logic [31:0] v);
		int k;
		@(posedge i_ref_clk);
		psel <= 1'b1;
		pwrite <= we;
		paddr <= a;
		pwdata <= v;
		@(posedge i_ref_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge i_ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=1", $time, pready);
			test_done;
		end
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Reset values, early requests, unmapped access
	task t_reset;
		apb(0, A_ST, 0);
		chk(rd, 32'h0a1);
		apb(0, 12'h010, 0);
		chk({rd[30:0], serr}, 32'h1);
		apb(1, A_CT, 32'h18);
		@(posedge i_ref_clk);
		chk({irq_te, irq_tn, irq, irq_rf, irq_re}, 32'h1c);
	endtask

	// Data written before enables; second frame queued mid-frame
	task t_tx;
		apb(1, A_TX, 32'h5a);
		apb(1, A_CT, 32'h2c19);
		fork
			i_su_far_node.get_async(d, mp, ok, w);
			apb(1, A_TX, 32'hc3);
		join
		chk({ok, mp, d}, 32'h35a);
		i_su_far_node.get_async(d, mp, ok, w);
		chk({w <= 10, ok, mp, d}, 32'h7c3);
		chk({irq_tn, tx_pin, irq_te, irq}, 32'hf);
	endtask

	// ID wait drops a data frame, an ID frame ends the wait
	task t_mprx;
		apb(1, A_CT, 32'h422);
		i_su_far_node.send_async(8'h11, 1'b0);
		apb(0, A_ST, 0);
		chk(rd & 32'h5e, 32'h0);
		i_su_far_node.send_async(8'h3c, 1'b1);
		apb(0, A_ST, 0);
		chk(rd & 32'h5e, 32'h42);
		apb(0, A_CT, 0);
		chk(rd, 32'h402);
		apb(0, A_RX, 0);
		chk(rd, 32'h3c);
		i_su_far_node.send_async(8'h77, 1'b0);
		apb(0, A_RX, 0);
		chk(rd, 32'h77);
		apb(0, A_ST, 0);
		chk(rd & 32'h5e, 32'h0);
	endtask

	// Clocked receive, overrun, halt on error, resume after clear
	task t_sync;
		apb(1, A_CT, 32'h46);
		i_su_far_node.send_sync(8'ha6);
		chk({irq_rf, irq_re}, 32'h2);
		i_su_far_node.send_sync(8'h3b);
		chk({irq_rf, irq_re}, 32'h3);
		apb(0, A_RX, 0);
		chk(rd, 32'ha6);
		i_su_far_node.send_sync(8'h99);
		apb(0, A_ST, 0);
		chk(rd & 32'h1e, 32'h04);
		apb(1, A_ST, 32'h0);
		i_su_far_node.send_sync(8'h42);
		apb(0, A_RX, 0);
		chk(rd, 32'h42);
	endtask

	// Clocked send on the unit's own clock; line keeps MSB, clock idles
	task t_stx;
		apb(1, A_TX, 32'h5c);
		apb(1, A_CT, 32'hc1);
		i_su_far_node.get_sync(d, ok);
		chk({ok, d}, 32'h15c);
		apb(0, A_ST, 0);
		chk({sck_oe, sck_dev, tx_pin, rd[7:0]}, 32'h6a1);
	endtask

	initial begin
		repeat (8) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		t_reset;
		t_tx;
		t_mprx;
		t_sync;
		t_stx;
		test_done;
	end

	// Watchdog against a hung frame or handshake
	initial begin
		#1000000;
		err_total++;
		$display("ERROR t=%0t got=%h exp=%h", $time, 1'b1, 1'b0);
		test_done;
	end
endmodule // tb_su_serial_unit
